// ### rtl/cal_agc_top.sv
// per-channel automatic level loop: forward gain, feedback and timing
//
// Overview of operation
// R1 - shifter gives 0 to 90 dB, 6 dB steps
// R2 - multiplier 1.0 to 2.0, output saturates
// R3 - forward gain never below unity
// R4 - gain word: 4-bit exponent plus mantissa
// R5 - coefficient is 01 above the mantissa
// R6 - error is threshold minus output magnitude, integrated
// R7 - integrator held within upper and lower limits
// R8 - gain word readable and sent with samples
// R9 - slot counter wraps, restarts on aligned sync
// R10 - delay counter gates gain timing after sync
// R11 - interval counter splits slot; off means continuous
// R12 - sync alignment only when enabled
// R13 - measure delay input, scale delay output
// R14 - sampled mode adapts early, then holds gain
// R15 - timed mode switches loop gain set
// R16 - upstream keeps 2, 4 or 1 clock spacing
// R17 - magnitude iterates one pass per clock
// R18 - set point comes from threshold setting
// R19 - mean mode adds scaled error
// R20 - median mode steps by error sign
// R21 - two loop gain sets, attack and decay
// R22 - holding gain copied on strobe or sync
// R23 - integrator clamps at a limit
`timescale 1ns/100ps
module cal_agc_top
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// samples from the channel filter
	input wire logic i_sample_vld,
	input wire logic signed [cal_pkg::CAL_DW-1:0] i_i,
	input wire logic signed [cal_pkg::CAL_DW-1:0] i_q,
	// frame alignment pin
	input wire logic i_external_frame_align_in,
	// configuration
	input wire logic i_bypass,
	input wire cal_pkg::cal_mode_e i_mode,
	input wire logic i_align_en,
	input wire logic i_sync_load_en,
	input wire logic [cal_pkg::CAL_CNT_W-1:0] i_slot_len,
	input wire logic [cal_pkg::CAL_CNT_W-1:0] i_delay_clks,
	input wire logic [cal_pkg::CAL_CNT_W-1:0] i_interval,
	input wire logic [cal_pkg::CAL_DLY_AW-1:0] i_data_delay,
	input wire logic [cal_pkg::CAL_PASS_W-1:0] i_passes,
	input wire logic [cal_pkg::CAL_MAG_W-1:0] i_threshold,
	// loop gain control
	input wire logic i_loop_sel,
	input wire logic i_median,
	input wire logic i_cnt_loop_sel,
	input wire logic i_cnt_mode_sel,
	input wire logic [cal_pkg::CAL_LG_W-1:0] i_attack0,
	input wire logic [cal_pkg::CAL_LG_W-1:0] i_decay0,
	input wire logic [cal_pkg::CAL_LG_W-1:0] i_attack1,
	input wire logic [cal_pkg::CAL_LG_W-1:0] i_decay1,
	// gain limits and load
	input wire logic [cal_pkg::CAL_GW-1:0] i_gain_upper,
	input wire logic [cal_pkg::CAL_GW-1:0] i_gain_lower,
	input wire logic [cal_pkg::CAL_GW-1:0] i_gain_hold,
	input wire logic i_gain_load_stb,
	// scaled samples and gain
	output logic o_sample_vld,
	output logic signed [cal_pkg::CAL_DW-1:0] o_i,
	output logic signed [cal_pkg::CAL_DW-1:0] o_q,
	output logic [cal_pkg::CAL_GW-1:0] o_gain_rt,
	output logic [cal_pkg::CAL_GW-1:0] o_gain_word,
	output logic o_in_interval
);
	import cal_pkg::*;

	typedef struct packed {
		logic [2:0] sy;
		logic sy_lvl;
		logic [CAL_CNT_W-1:0] slot_cnt;
		logic [CAL_CNT_W-1:0] dly_cnt;
		logic dly_run;
		logic [CAL_CNT_W-1:0] int_cnt;
		logic in_int;
		logic [CAL_DLY_AW-1:0] wp;
		logic in_vld;
		logic dly_on;
		logic signed [CAL_DW-1:0] in_i;
		logic signed [CAL_DW-1:0] in_q;
		logic [CAL_ACC_W-1:0] acc;
		logic o_vld;
		logic signed [CAL_DW-1:0] o_i;
		logic signed [CAL_DW-1:0] o_q;
		logic [CAL_GW-1:0] o_gain;
	} cal_top_s;

	cal_top_s st_r;
	cal_top_s st_nxt;

	logic cnt_on;
	logic agreed;
	logic ext_edge;
	logic frame_sync;
	logic slot_wrap;
	logic [CAL_DLY_AW-1:0] eff_dly;
	logic [2*CAL_DW-1:0] rd_data;
	logic signed [CAL_DW-1:0] src_i;
	logic signed [CAL_DW-1:0] src_q;
	logic [CAL_GW-1:0] gain;
	logic mag_done;
	logic [CAL_MAG_W-1:0] mag;
	logic set_sel;
	logic med_sel;
	logic [CAL_LG_W-1:0] sh;
	logic signed [19:0] err;
	logic signed [27:0] delta;
	logic signed [27:0] sum;
	logic signed [27:0] lim_lo;
	logic signed [27:0] lim_hi;
	logic upd_en;
	logic load;

	assign gain = st_r.acc[CAL_ACC_W-1:CAL_FRAC_W]; // see R4
	assign cnt_on = (i_mode != CAL_CONT); // see R11

	// pin sampler: ff2 and ff3 must agree before a level counts
	always_comb
	begin
		agreed = (st_r.sy[1] == st_r.sy[2]);
		ext_edge = agreed && st_r.sy[2] && !st_r.sy_lvl;
		// greater-or-equal so a shortened slot wraps at once
		slot_wrap = (st_r.slot_cnt >= 16'(i_slot_len - 16'h0001));
		frame_sync = (ext_edge && i_align_en) || slot_wrap; // see R12
		load = i_gain_load_stb || (ext_edge && i_sync_load_en); // see R22
		// sampled mode always runs with at least one sample of delay
		eff_dly = i_data_delay;
		if (i_mode == CAL_SAMPLED && i_data_delay == 4'h0)
			eff_dly = 4'h1; // see R14
		src_i = st_r.dly_on ? rd_data[2*CAL_DW-1:CAL_DW] : st_r.in_i;
		src_q = st_r.dly_on ? rd_data[CAL_DW-1:0] : st_r.in_q;
	end

	// delay line: loop sees the entering sample, output the leaving one
	cal_dly_mem u_dly
	(
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_wr_en(i_sample_vld),
		.i_wr_addr(st_r.wp),
		.i_wr_data({i_i, i_q}),
		.i_rd_addr(st_r.wp - eff_dly), // see R13
		.o_rd_data(rd_data)
	);

	// magnitude of the entering sample under the present gain
	cal_mag u_mag
	(
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_start(st_r.in_vld),
		.i_i(cal_scale(st_r.in_i, gain)), // see R6
		.i_q(cal_scale(st_r.in_q, gain)),
		.i_passes(i_passes),
		.o_done(mag_done), // see R17
		.o_mag(mag)
	);

	// loop gain set, settling mode and scaled error
	always_comb
	begin
		set_sel = (cnt_on && i_cnt_loop_sel) ? !st_r.in_int : i_loop_sel;
		med_sel = (cnt_on && i_cnt_mode_sel) ? st_r.in_int : i_median;
		err = $signed({2'h0, i_threshold}) - $signed({2'h0, mag}); // see R18
		// negative error means too loud, so the attack shift applies
		if (err < 0)
			sh = set_sel ? i_attack1 : i_attack0; // see R21
		else
			sh = set_sel ? i_decay1 : i_decay0; // see R15
		if (med_sel)
		begin
			delta = $signed(CAL_MED_STEP >> sh); // see R20
			if (err < 0)
				delta = -delta;
		end
		else
			delta = ($signed({{8{err[19]}}, err}) <<< CAL_FRAC_W) >>> sh; // see R19
		sum = $signed({2'h0, st_r.acc}) + delta;
		lim_lo = $signed({2'h0, i_gain_lower, 8'h00});
		lim_hi = $signed({2'h0, i_gain_upper, 8'h00});
		// sampled mode only adapts inside the measure interval
		upd_en = mag_done && ((i_mode != CAL_SAMPLED) || st_r.in_int);
	end

	// next state of counters, sample path and integrator
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sy = {st_r.sy[1:0], i_external_frame_align_in};
		if (agreed)
			st_nxt.sy_lvl = st_r.sy[2];
		// slot, delay and interval counters idle in continuous mode
		if (!cnt_on)
		begin
			st_nxt.slot_cnt = '0;
			st_nxt.dly_run = 1'b0;
			st_nxt.in_int = 1'b0;
		end
		else
		begin
			if (frame_sync)
				st_nxt.slot_cnt = '0; // see R9
			else
				st_nxt.slot_cnt = st_r.slot_cnt + 16'h0001;
			if (st_r.in_int)
			begin
				st_nxt.int_cnt = st_r.int_cnt - 16'h0001;
				if (st_r.int_cnt == 16'h0001)
					st_nxt.in_int = 1'b0;
			end
			if (frame_sync)
			begin
				st_nxt.dly_cnt = i_delay_clks; // see R10
				st_nxt.dly_run = 1'b1;
			end
			else if (st_r.dly_run)
			begin
				st_nxt.dly_cnt = st_r.dly_cnt - 16'h0001;
				if (st_r.dly_cnt == 16'h0000)
				begin
					st_nxt.dly_run = 1'b0;
					st_nxt.int_cnt = i_interval; // see R11
					st_nxt.in_int = (i_interval != 16'h0000);
				end
			end
		end
		// input stage: write pointer moves with every accepted sample
		st_nxt.in_vld = i_sample_vld && !i_bypass;
		if (i_sample_vld)
		begin
			st_nxt.wp = st_r.wp + 4'h1;
			st_nxt.in_i = i_i;
			st_nxt.in_q = i_q;
			st_nxt.dly_on = (eff_dly != 4'h0);
		end
		// forward path: gain only ever adds, saturating at full scale
		st_nxt.o_vld = 1'b0;
		if (i_sample_vld && i_bypass)
		begin
			st_nxt.o_vld = 1'b1;
			st_nxt.o_i = i_i;
			st_nxt.o_q = i_q;
			st_nxt.o_gain = gain;
		end
		else if (st_r.in_vld)
		begin
			st_nxt.o_vld = 1'b1;
			st_nxt.o_i = cal_scale(src_i, gain); // see R1
			st_nxt.o_q = cal_scale(src_q, gain); // see R2
			st_nxt.o_gain = gain; // see R8
		end
		// integrator: a load beats an update, limits clamp the sum
		if (load)
			st_nxt.acc = {i_gain_hold, 8'h00}; // see R22
		else if (upd_en)
		begin
			if (sum < lim_lo)
				st_nxt.acc = lim_lo[CAL_ACC_W-1:0]; // see R23
			else if (sum > lim_hi)
				st_nxt.acc = lim_hi[CAL_ACC_W-1:0]; // see R7
			else
				st_nxt.acc = sum[CAL_ACC_W-1:0];
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			st_r <= '0;
			st_r.sy <= CAL_SYNC_RST;
			st_r.acc <= CAL_ACC_RST;
		end
		else
			st_r <= st_nxt;
	end

	// outputs straight from the state register
	assign o_sample_vld = st_r.o_vld;
	assign o_i = st_r.o_i;
	assign o_q = st_r.o_q;
	assign o_gain_rt = st_r.o_gain;
	assign o_gain_word = gain; // see R8
	assign o_in_interval = st_r.in_int;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	property p_load;
		i_gain_load_stb |=> o_gain_word == $past(i_gain_hold);
	endproperty
	a_load: assert property (p_load) // see R22
		else $error("holding gain not copied on strobe");

	property p_clamp;
		(!$past(load) && $past(upd_en) && i_gain_lower <= i_gain_upper
			&& $stable(i_gain_lower) && $stable(i_gain_upper))
		|-> o_gain_word >= i_gain_lower && o_gain_word <= i_gain_upper;
	endproperty
	a_clamp: assert property (p_clamp) // see R7
		else $error("gain left the programmed limits");

	property p_hold;
		(i_mode == CAL_SAMPLED && !st_r.in_int && !load) |=> $stable(st_r.acc);
	endproperty
	a_hold: assert property (p_hold) // see R14
		else $error("gain changed in sampled hold period");

	property p_rt_gain;
		(st_r.in_vld && !(i_sample_vld && i_bypass)) |=>
			o_sample_vld && o_gain_rt == $past(gain);
	endproperty
	a_rt_gain: assert property (p_rt_gain) // see R8
		else $error("real time gain does not follow sample");

	property p_bypass;
		(i_sample_vld && i_bypass) |=>
			o_sample_vld && o_i == $past(i_i) && o_q == $past(i_q);
	endproperty
	a_bypass: assert property (p_bypass) // see R3
		else $error("bypass does not pass the sample");

	property p_unity;
		(st_r.in_vld && !i_bypass && !i_sample_vld && !st_r.dly_on
			&& st_r.in_i > 0) |=> o_i >= $past(st_r.in_i);
	endproperty
	a_unity: assert property (p_unity) // see R3
		else $error("forward path attenuated a sample");

	property p_slot;
		(cnt_on && $past(cnt_on) && i_slot_len != 16'h0000
			&& $stable(i_slot_len)) |-> st_r.slot_cnt < i_slot_len;
	endproperty
	a_slot: assert property (p_slot) // see R9
		else $error("slot counter passed its length");

	property p_delay;
		(cnt_on && frame_sync && i_delay_clks == 16'h0005
			&& i_interval != 16'h0000) ##1 (!frame_sync)[*6]
		|=> st_r.in_int;
	endproperty
	a_delay: assert property (p_delay) // see R10
		else $error("interval did not open after delay");

	property p_cont;
		(i_mode == CAL_CONT) |=> !st_r.in_int && !st_r.dly_run;
	endproperty
	a_cont: assert property (p_cont) // see R11
		else $error("counters ran in continuous mode");

	c_load: cover property (i_gain_load_stb ##1 o_sample_vld);
	c_median: cover property (upd_en && med_sel && !load);
	c_sat: cover property (o_sample_vld && o_i == 16'h7FFF);
	c_sampled: cover property (i_mode == CAL_SAMPLED && st_r.in_int);
endmodule

// ### rtl/cal_pkg.sv
// shared constants, types and scaling function of the channel level loop
package cal_pkg;

	// sample and gain word widths
	localparam int CAL_DW = 16;
	localparam int CAL_EXP_W = 4;
	localparam int CAL_GAIN_MANTISSA_W = 14;
	localparam int CAL_GW = CAL_EXP_W + CAL_GAIN_MANTISSA_W;
	localparam int CAL_FRAC_W = 8;
	localparam int CAL_ACC_W = CAL_GW + CAL_FRAC_W;
	localparam int CAL_MAG_W = 18;
	localparam int CAL_CNT_W = 16;
	localparam int CAL_DLY_AW = 4;
	localparam int CAL_LG_W = 5;
	localparam int CAL_PASS_W = 4;

	// fixed top bits of the multiplier coefficient
	localparam logic [1:0] CAL_MULT_HI = 2'h1;
	// pass count limits of the magnitude iteration
	localparam logic [3:0] CAL_MIN_PASSES = 4'h2;
	localparam logic [3:0] CAL_MAX_PASSES = 4'h8;
	// median step before loop gain shift
	localparam logic [27:0] CAL_MED_STEP = 28'h0010000;
	// reset values
	localparam logic [CAL_ACC_W-1:0] CAL_ACC_RST = 26'h0000000;
	localparam logic [2:0] CAL_SYNC_RST = 3'h0;
	// saturation bounds of the forward path
	localparam logic signed [48:0] CAL_SAT_HI = 49'sh00000_0000_7FFF;
	localparam logic signed [48:0] CAL_SAT_LO = -49'sh00000_0000_8000;

	// operating modes of the loop timing
	typedef enum logic [1:0] {
		CAL_CONT = 2'h0,
		CAL_TIMED = 2'h1,
		CAL_SAMPLED = 2'h3
	} cal_mode_e;

	// magnitude iteration states
	typedef enum logic {
		CAL_MAG_IDLE = 1'h0,
		CAL_MAG_RUN = 1'h1
	} cal_mag_state_e;

	// scale a sample by 2^exp * (1 + gain_mantissa), saturating to the sample width
	function automatic logic signed [CAL_DW-1:0] cal_scale(
		input logic signed [CAL_DW-1:0] x,
		input logic [CAL_GW-1:0] g);
		logic signed [32:0] p;
		logic signed [48:0] s;
		p = x * $signed({1'b0, CAL_MULT_HI, g[CAL_GAIN_MANTISSA_W-1:0]}); // see R5
		s = {{16{p[32]}}, p};
		s = s <<< g[CAL_GW-1:CAL_GAIN_MANTISSA_W];
		s = s >>> CAL_GAIN_MANTISSA_W;
		if (s > CAL_SAT_HI)
			cal_scale = 16'h7FFF;
		else if (s < CAL_SAT_LO)
			cal_scale = 16'h8000;
		else
			cal_scale = s[CAL_DW-1:0];
	endfunction

endpackage

// ### rtl/cal_dly_mem.sv
// sample delay memory with registered read data
`timescale 1ns/100ps
module cal_dly_mem
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// write side
	input wire logic i_wr_en,
	input wire logic [cal_pkg::CAL_DLY_AW-1:0] i_wr_addr,
	input wire logic [2*cal_pkg::CAL_DW-1:0] i_wr_data,
	// read side
	input wire logic [cal_pkg::CAL_DLY_AW-1:0] i_rd_addr,
	output logic [2*cal_pkg::CAL_DW-1:0] o_rd_data
);
	import cal_pkg::*;

	typedef struct packed {
		logic [15:0][2*CAL_DW-1:0] mem;
		logic [2*CAL_DW-1:0] rd;
	} cal_mem_s;

	cal_mem_s st_r;
	cal_mem_s st_nxt;

	// read returns the word stored before this cycle's write
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rd = st_r.mem[i_rd_addr];
		if (i_wr_en)
			st_nxt.mem[i_wr_addr] = i_wr_data;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_rd_data = st_r.rd;
endmodule

// ### rtl/cal_mag.sv
// iterative magnitude of an i/q pair, one rotation pass per clock
`timescale 1ns/100ps
module cal_mag
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// request
	input wire logic i_start,
	input wire logic signed [cal_pkg::CAL_DW-1:0] i_i,
	input wire logic signed [cal_pkg::CAL_DW-1:0] i_q,
	input wire logic [cal_pkg::CAL_PASS_W-1:0] i_passes,
	// answer
	output logic o_done,
	output logic [cal_pkg::CAL_MAG_W-1:0] o_mag
);
	import cal_pkg::*;

	typedef struct packed {
		cal_mag_state_e st;
		logic signed [18:0] x;
		logic signed [18:0] y;
		logic [3:0] k;
		logic [3:0] n;
		logic done;
		logic [CAL_MAG_W-1:0] mag;
	} cal_mag_s;

	cal_mag_s st_r;
	cal_mag_s st_nxt;
	logic last;
	logic [3:0] np;

	// result keeps the iteration gain, about 1.58 to 1.65 by pass count
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		last = (st_r.st == CAL_MAG_RUN) && (st_r.k == st_r.n - 4'h1);
		np = i_passes;
		if (np < CAL_MIN_PASSES)
			np = CAL_MIN_PASSES;
		if (np > CAL_MAX_PASSES)
			np = CAL_MAX_PASSES;
		if (st_r.st == CAL_MAG_RUN)
		begin
			if (!st_r.y[18])
			begin
				st_nxt.x = st_r.x + (st_r.y >>> st_r.k); // see R17
				st_nxt.y = st_r.y - (st_r.x >>> st_r.k);
			end
			else
			begin
				st_nxt.x = st_r.x - (st_r.y >>> st_r.k);
				st_nxt.y = st_r.y + (st_r.x >>> st_r.k);
			end
			st_nxt.k = st_r.k + 4'h1;
			if (last)
			begin
				st_nxt.st = CAL_MAG_IDLE;
				st_nxt.done = 1'b1;
				st_nxt.mag = st_nxt.x[CAL_MAG_W-1:0];
			end
		end
		// a new pair may enter on the final pass of the previous one
		if (i_start && (st_r.st == CAL_MAG_IDLE || last))
		begin
			st_nxt.st = CAL_MAG_RUN;
			st_nxt.x = i_i[CAL_DW-1] ? -19'(i_i) : 19'(i_i);
			st_nxt.y = 19'(i_q);
			st_nxt.k = 4'h0;
			st_nxt.n = np;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_done = st_r.done;
	assign o_mag = st_r.mag;

	// done follows an accepted start after the programmed passes
	property p_mag_lat;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(i_start && st_r.st == CAL_MAG_IDLE) |-> ##[3:9] o_done;
	endproperty
	a_mag_lat: assert property (p_mag_lat) // see R17
		else $error("magnitude result not produced in time");
endmodule

// ### verification/cal_src_model.sv
// upstream channel filter model that feeds i/q samples at a legal spacing
`timescale 1ns/100ps
module cal_src_model
(
	// clock
	input wire logic i_sys_clk,
	// minimum clocks between two samples
	input wire logic [2:0] i_gap,
	// sample stream toward the level loop
	output logic o_sample_vld,
	output logic signed [cal_pkg::CAL_DW-1:0] o_i,
	output logic signed [cal_pkg::CAL_DW-1:0] o_q
);
	import cal_pkg::*;

	int cyc = 0;
	int last = -8;

	// free cycle count, used only to hold the spacing
	always @(posedge i_sys_clk)
		cyc <= cyc + 1;

	// quiet stream at time zero
	initial
	begin
		o_sample_vld = 1'b0;
		o_i = '0;
		o_q = '0;
	end

	// one sample; returns at the edge that takes it
	task automatic send(input logic signed [CAL_DW-1:0] i, q);
		@(posedge i_sys_clk);
		while (cyc - last < int'(i_gap))
			@(posedge i_sys_clk);
		o_sample_vld <= 1'b1;
		o_i <= i;
		o_q <= q;
		last = cyc;
		@(posedge i_sys_clk);
		// released lines flip so a stale value never looks valid
		o_sample_vld <= 1'b0;
		o_i <= ~i;
		o_q <= ~q;
	endtask
endmodule

// ### verification/cal_agc_top_test.sv
// self-checking bench of the channel level loop
`timescale 1ns/100ps
module cal_agc_top_test;
	import cal_pkg::*;

	logic clk = 1'b0, rst = 1'b1, pin = 1'b0, byp = 1'b0, aen = 1'b0;
	logic sle = 1'b0, lsel = 1'b0, med = 1'b0, clsel = 1'b0, cmsel = 1'b0;
	logic stb = 1'b0, vld, o_vld, o_iv;
	cal_mode_e mode = CAL_CONT;
	logic [CAL_CNT_W-1:0] slen = 16'h0028, dclk = 16'h0005, ivl = 16'h000A;
	logic [CAL_DLY_AW-1:0] ddly = 4'h0;
	logic [CAL_PASS_W-1:0] pas = 4'h2;
	logic [CAL_MAG_W-1:0] thr = 18'h00100;
	logic [CAL_LG_W-1:0] at0 = 5'h08, de0 = 5'h08, at1 = 5'h08, de1 = 5'h08;
	logic [CAL_GW-1:0] gup = 18'h3FFFF, glo = 18'h00000, ghold = 18'h00000;
	logic [CAL_GW-1:0] g_rt, g_word;
	logic [2:0] gap = 3'h4;
	logic signed [CAL_DW-1:0] di, dq, oi, oq;
	int n_fail = 0;
	int checks_done = 0;
	int k;

	cal_agc_top u_cal_agc_top
	(
		.i_sys_clk(clk), .i_sys_rst(rst), .i_sample_vld(vld), .i_i(di),
		.i_q(dq), .i_external_frame_align_in(pin), .i_bypass(byp),
		.i_mode(mode), .i_align_en(aen), .i_sync_load_en(sle),
		.i_slot_len(slen), .i_delay_clks(dclk), .i_interval(ivl),
		.i_data_delay(ddly), .i_passes(pas), .i_threshold(thr),
		.i_loop_sel(lsel), .i_median(med), .i_cnt_loop_sel(clsel),
		.i_cnt_mode_sel(cmsel), .i_attack0(at0), .i_decay0(de0),
		.i_attack1(at1), .i_decay1(de1), .i_gain_upper(gup),
		.i_gain_lower(glo), .i_gain_hold(ghold), .i_gain_load_stb(stb),
		.o_sample_vld(o_vld), .o_i(oi), .o_q(oq), .o_gain_rt(g_rt),
		.o_gain_word(g_word), .o_in_interval(o_iv)
	);

	cal_src_model u_cal_src_model
	(
		.i_sys_clk(clk), .i_gap(gap), .o_sample_vld(vld), .o_i(di), .o_q(dq)
	);

	// 100 MHz clock
	initial
	begin
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] got, want);
		checks_done++;
		if (got !== want)
		begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", what, want, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic lost();
		check("bounded wait", 1'b0, 1'b1);
		tally_and_finish();
	endtask

	// ideal 2^exp * (1 + gain_mantissa) with truncation and saturation
	function automatic logic [CAL_DW-1:0] ideal(
		input logic signed [CAL_DW-1:0] x, input logic [CAL_GW-1:0] g);
		longint m;
		longint p;
		m = 16384 + g[13:0];
		p = (longint'(x) * m) <<< g[17:14];
		p = p >>> 14;
		if (p > 32767)
			p = 32767;
		else if (p < -32768)
			p = -32768;
		return p[15:0];
	endfunction

	// set limits, then copy the holding gain in by strobe
	task automatic lim_load(input logic [CAL_GW-1:0] lo, hi, g);
		@(posedge clk);
		glo <= lo;
		gup <= hi;
		ghold <= g;
		stb <= 1'b1;
		@(posedge clk);
		stb <= 1'b0;
		@(posedge clk);
		#1;
		check("loaded gain", g_word, g);
	endtask

	// wait for the scaled sample; bypass answers one cycle sooner
	task automatic get_out();
		int n;
		n = 0;
		#1;
		while (o_vld !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 8)
			lost();
	endtask

	// count clocks until the interval flag shows the wanted level
	task automatic lvl(input logic v);
		k = 0;
		#1;
		while (o_iv !== v && k < 100)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k == 100)
			lost();
	endtask

	// gain pinned by equal limits, so the output is exactly predictable
	task automatic fwd(input logic [CAL_GW-1:0] g,
		input logic signed [CAL_DW-1:0] x);
		lim_load(g, g, g);
		u_cal_src_model.send(x, -x);
		get_out();
		check("scaled i", {oi}, ideal(x, g));
		check("scaled q", {oq}, ideal(-x, g));
		check("gain with sample", g_rt, g);
	endtask

	// one sample, then the integrator after its update has landed
	task automatic step(input logic signed [CAL_DW-1:0] x,
		input logic [CAL_GW-1:0] g);
		u_cal_src_model.send(x, x);
		repeat (12) @(posedge clk);
		#1;
		check("loop gain", g_word, g);
	endtask

	// three-clock pulse; the sampler drops anything under two clocks
	task automatic pulse();
		@(posedge clk);
		pin <= 1'b1;
		repeat (3) @(posedge clk);
		pin <= 1'b0;
	endtask

	// main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check("reset gain", g_word, 18'h00000);
		check("reset valid", o_vld, 1'b0);
		$display("test reset done");
		// every shift step, mantissa weights, both saturation sides
		for (int e = 0; e < 16; e++)
			fwd({e[3:0], 14'h0000}, 16'sh0001);
		fwd(18'h0E000, 16'sh0064);
		fwd(18'h0BFFF, -16'sh1F40);
		fwd(18'h05000, -16'sh0004);
		$display("test forward done");
		@(posedge clk);
		byp <= 1'b1;
		gap <= 3'h1;
		u_cal_src_model.send(16'sh1234, -16'sh0567);
		get_out();
		check("bypass i", {oi}, 16'h1234);
		check("bypass q", {oq}, 16'hFA99);
		@(posedge clk);
		byp <= 1'b0;
		gap <= 3'h4;
		$display("test bypass done");
		// zero input gives zero magnitude, so the error is the set point
		lim_load(18'h00000, 18'h3FFFF, 18'h00000);
		step(16'sh0000, 18'h00001);
		step(16'sh0000, 18'h00002);
		@(posedge clk);
		med <= 1'b1;
		de0 <= 5'h04;
		step(16'sh0000, 18'h00012);
		@(posedge clk);
		lsel <= 1'b1;
		de1 <= 5'h02;
		step(16'sh0000, 18'h00052);
		@(posedge clk);
		gup <= 18'h00055;
		step(16'sh0000, 18'h00055);
		@(posedge clk);
		thr <= 18'h00000;
		glo <= 18'h00050;
		at1 <= 5'h00;
		step(16'sh03E8, 18'h00050);
		$display("test loop done");
		@(posedge clk);
		glo <= 18'h00000;
		ghold <= 18'h00003;
		sle <= 1'b1;
		pulse();
		repeat (8) @(posedge clk);
		#1;
		check("pin load", g_word, 18'h00003);
		@(posedge clk);
		sle <= 1'b0;
		ghold <= 18'h00007;
		pulse();
		repeat (8) @(posedge clk);
		#1;
		check("pin load off", g_word, 18'h00003);
		$display("test sync load done");
		// a long slot keeps counter syncs away from the pin measurement
		@(posedge clk);
		mode <= CAL_TIMED;
		aen <= 1'b1;
		slen <= 16'hFFFF;
		pulse();
		lvl(1'b1);
		check("sync to interval", k >= 6 && k <= 12, 1'b1);
		lvl(1'b0);
		@(posedge clk);
		slen <= 16'h0028;
		pulse();
		lvl(1'b1);
		lvl(1'b0);
		check("interval length", k, 10);
		lvl(1'b1);
		check("slot period", k + 10, 40);
		@(posedge clk);
		aen <= 1'b0;
		lvl(1'b0);
		pulse();
		lvl(1'b1);
		check("pin ignored", k + 4, 30);
		@(posedge clk);
		mode <= CAL_SAMPLED;
		med <= 1'b0;
		lsel <= 1'b0;
		de0 <= 5'h08;
		thr <= 18'h00100;
		lim_load(18'h00000, 18'h3FFFF, 18'h00000);
		lvl(1'b1);
		lvl(1'b0);
		step(16'sh0000, 18'h00000);
		lvl(1'b1);
		step(16'sh0000, 18'h00001);
		// delay of one: each output carries the sample before it
		u_cal_src_model.send(16'sh0100, 16'sh0100);
		get_out();
		check("delayed first", {oi}, 16'h0000);
		u_cal_src_model.send(16'sh0200, 16'sh0200);
		get_out();
		check("delayed i", {oi}, ideal(16'sh0100, 18'h00001));
		$display("test counters done");
		// counters pick set1 and mean outside, set0 and median inside
		repeat (6) @(posedge clk);
		mode <= CAL_TIMED;
		clsel <= 1'b1;
		cmsel <= 1'b1;
		de1 <= 5'h06;
		thr <= 18'h00200;
		lvl(1'b1);
		lvl(1'b0);
		step(16'sh0000, 18'h00009);
		lvl(1'b1);
		step(16'sh0000, 18'h0000A);
		$display("test counter select done");
		tally_and_finish();
	end
endmodule
